//--- src/rail_pid_map.svh
// Offsets, field positions, reset values and timing counts of the rail pressure controller.
// Assumes inclusion by bare name from the package and the testbench.
`ifndef RAIL_PID_MAP_SVH
`define RAIL_PID_MAP_SVH
`define RP_CLK_HZ 10000000
`define RP_UPDATE_US 1000
`define RP_UPDATE_CYC ((`RP_CLK_HZ / 1000000) * `RP_UPDATE_US)
`define RP_PWM_PERIOD 8'd100
// Register byte offsets
`define RP_OFF_CTRL 8'h00
`define RP_OFF_SETPOINT 8'h04
`define RP_OFF_THRESH 8'h08
`define RP_OFF_GAIN 8'h0C
`define RP_OFF_TI 8'h10
`define RP_OFF_TD 8'h14
`define RP_OFF_LIMITS 8'h18
`define RP_OFF_FF 8'h1C
`define RP_OFF_BATT_MAX 8'h20
`define RP_OFF_AUX_CFG 8'h24
`define RP_OFF_STATUS 8'h28
`define RP_OFF_TERMS 8'h2C
`define RP_OFF_DUTY 8'h30
`define RP_OFF_AUX_OUT 8'h34
// Control fields
`define RP_CTRL_MODE 0
`define RP_CTRL_INLET_EN 1
`define RP_CTRL_HPV_EN 2
`define RP_CTRL_CHAN_LO 4
`define RP_CTRL_LOCK 6
`define RP_CTRL_CLEAR 7
`define RP_CTRL_AUX_OVR 8
// Reset values
`define RP_THRESH_RST 16'h0FFF
`define RP_OUTMAX_RST 8'h1E
`endif

//--- src/rail_pid_pkg.sv
// Types shared by the rail pressure controller.
// Assumes the map header is on the include path.
`include "rail_pid_map.svh"
package rail_pid_pkg;
  typedef enum logic [0:0] {MODE_INLET = 1'b0, MODE_HIGH = 1'b1} loop_valve_select_e;
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
    logic [31:0] hwdata;
  } ahb_req_s;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_s;
endpackage : rail_pid_pkg

//--- src/rail_pressure_pid_control.sv
// Rail pressure PID control with auxiliary loop tail, AHB-Lite register slave.
// Assumes pressure samples in bar on four analog inputs, synchronous to clk_in.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
// How it works
// [R1] Auxiliary combined output is its limited PID output plus feed forward.
// [R2] Auxiliary override enable replaces the combined output with the override value.
// [R3] Each enabled target selector entry receives the auxiliary combined output; here no enable exists and every entry receives it.
// [R4] Only one loop, inlet or high pressure, runs at any time.
// [R5] The non-loop valve gets constant duty at the fixed PWM frequency.
// [R6] In high pressure mode the inlet valve runs at its constant duty.
// [R7] Inlet feed forward adds to the limited inlet output, inlet mode only.
// [R8] Pressure above threshold latches a fault and turns off all channels.
// [R9] The fault stays set until software writes the clear bit.
// [R10] A selector picks one of four analog channels as pressure feedback.
// [R11] Presence flag is true only when module inserted and powered.
// [R12] Battery derived maximum duty keeps valve current at or below 3A.
// [R13] Channel locking drives channels one-two and three-four as pairs.
// [R14] Inlet PWM reaches its channels only while inlet enable is on.
// [R15] Zero gain kills all terms; negative gain inverts the error.
// [R16] Zero integral time disables integral; smaller times strengthen it.
// [R17] Zero derivative time disables derivative; larger times strengthen it.
// [R18] Inlet output clamps to min and max (max 0..30%) before feed forward.
// [R19] Proportional, integral and derivative terms are readable.
// [R20] The active loop is evaluated once per fixed update period.
// [R21] Final duty is bounded by min and by the lower of max and battery max.
module rail_pressure_pid_control #(
  parameter int UPDATE_CYC = `RP_UPDATE_CYC,
  parameter int TARGETS = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire rail_pid_pkg::ahb_req_s ahb_in,
  output rail_pid_pkg::ahb_rsp_s ahb_out,
  input wire logic [63:0] analog_in,
  input wire logic module_inserted_in,
  input wire logic module_powered_in,
  input wire logic [15:0] aux_loop_pid_in,
  output logic [3:0] lowside_out,
  output logic driver_module_present_out,
  output logic pressure_fault_flag_out,
  output logic [TARGETS*8-1:0] aux_target_values_out
);
  import rail_pid_pkg::*;

  initial begin
    if (TARGETS < 1 || TARGETS > 8 || UPDATE_CYC < 2) begin
      $error("rail_pressure_pid_control: unsupported parameters");
    end
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] setpoint;
    logic [15:0] thresh;
    logic signed [15:0] gain;
    logic [15:0] ti;
    logic [15:0] td;
    logic [15:0] limits;
    logic [31:0] ff;
    logic [7:0] batt_max;
    logic [15:0] aux_cfg;
    logic fault;
    logic signed [31:0] integ;
    logic signed [15:0] prev_err;
    logic signed [15:0] p_term;
    logic signed [15:0] i_term;
    logic signed [15:0] d_term;
    logic [7:0] inlet_duty;
    logic [7:0] high_duty;
    logic [7:0] aux_out;
    logic [31:0] tick;
    logic [7:0] pwm_cnt;
    logic [3:0] ls;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [31:0] rdata;
  } state_s;

  state_s s_q, s_d;

  // ------------------------------------------------------------
  // Combinational helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] clamp8(input logic signed [17:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    logic signed [17:0] r;
    r = v;
    if (r > $signed({10'h000, hi})) r = $signed({10'h000, hi});
    if (r < $signed({10'h000, lo})) r = $signed({10'h000, lo});
    return r[7:0];
  endfunction : clamp8

  logic [15:0] pressure;
  logic signed [16:0] err17;
  logic signed [15:0] err;
  logic [7:0] out_max_eff;
  logic [7:0] duty_max_eff;
  logic signed [17:0] pid_sum;
  logic [7:0] pid_lim;
  logic over_pressure;
  logic bus_take;

  // Feedback channel and error
  always_comb begin
    pressure = analog_in[s_q.ctrl[`RP_CTRL_CHAN_LO +: 2]*16 +: 16]; // R10
    err17 = $signed({1'b0, s_q.setpoint}) - $signed({1'b0, pressure});
    err = (err17 > 17'sd32767) ? 16'sh7FFF : (err17 < -17'sd32768) ? 16'sh8000 : err17[15:0];
    over_pressure = pressure > s_q.thresh; // R8
    out_max_eff = (s_q.limits[15:8] > `RP_OUTMAX_RST) ? `RP_OUTMAX_RST : s_q.limits[15:8]; // R18
    duty_max_eff = (s_q.ff[31:24] < s_q.batt_max) ? s_q.ff[31:24] : s_q.batt_max; // R12 R21
    pid_sum = 18'(s_q.p_term) + 18'(s_q.i_term) + 18'(s_q.d_term);
    pid_lim = clamp8(pid_sum, s_q.limits[7:0], out_max_eff); // R18
    bus_take = ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1];
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic signed [31:0] e_gain;
    logic signed [31:0] de;
    logic [7:0] loop_duty;
    logic [7:0] aux_comb;
    s_d = s_q;
    e_gain = 32'(s_q.gain) * 32'(err);
    de = 32'(err) - 32'(s_q.prev_err);
    loop_duty = 8'h00;
    aux_comb = 8'h00;
    s_d.tick = (s_q.tick >= 32'(UPDATE_CYC - 1)) ? 32'h0 : s_q.tick + 32'h1;
    // One loop evaluation per update period on the selected valve only
    if (s_q.tick == 32'h0) begin // R20 R4
      s_d.prev_err = err;
      if (s_q.gain == 16'sh0000) begin // R15
        s_d.p_term = 16'sh0000;
        s_d.i_term = 16'sh0000;
        s_d.d_term = 16'sh0000;
      end else begin
        s_d.p_term = 16'(e_gain >>> 8); // R15
        if (s_q.ti == 16'h0000) begin // R16
          s_d.integ = 32'sh0;
        end else begin
          s_d.integ = s_q.integ + e_gain / $signed({16'h0000, s_q.ti}); // R16
        end
        s_d.i_term = 16'(s_d.integ >>> 8);
        s_d.d_term = (s_q.td == 16'h0000) ? 16'sh0000 : // R17
                     16'((32'(s_q.gain) * de * $signed({16'h0000, s_q.td})) >>> 16);
      end
      loop_duty = clamp8(18'(pid_lim) + 18'(s_q.ff[7:0]), s_q.limits[7:0] & 8'h00,
                         8'hFF); // R7
      if (s_q.ctrl[`RP_CTRL_MODE] == MODE_INLET) begin
        s_d.inlet_duty = clamp8(18'(loop_duty), s_q.ff[23:16], duty_max_eff); // R21
        s_d.high_duty = clamp8(18'(s_q.ff[15:8]), s_q.ff[23:16], duty_max_eff); // R5
      end else begin
        s_d.high_duty = clamp8(18'(pid_lim), s_q.ff[23:16], duty_max_eff); // R4
        s_d.inlet_duty = clamp8(18'(s_q.ff[15:8]), s_q.ff[23:16], duty_max_eff); // R6 R5
      end
    end
    // Auxiliary loop tail
    aux_comb = clamp8(18'($signed(aux_loop_pid_in)) + 18'(s_q.aux_cfg[7:0]), 8'h00,
                      8'hFF); // R1
    s_d.aux_out = s_q.ctrl[`RP_CTRL_AUX_OVR - 1] ? s_q.aux_cfg[15:8] : aux_comb; // R2
    // Shared PWM counter, fixed frequency for both valves
    s_d.pwm_cnt = (s_q.pwm_cnt >= `RP_PWM_PERIOD - 8'd1) ? 8'h00 : s_q.pwm_cnt + 8'h01;
    s_d.ls[0] = s_q.ctrl[`RP_CTRL_INLET_EN] && (s_q.pwm_cnt < s_q.inlet_duty); // R14
    s_d.ls[1] = s_q.ctrl[`RP_CTRL_LOCK] ? s_d.ls[0] : 1'b0; // R13
    s_d.ls[2] = s_q.ctrl[`RP_CTRL_HPV_EN] && (s_q.pwm_cnt < s_q.high_duty);
    s_d.ls[3] = s_q.ctrl[`RP_CTRL_LOCK] ? s_d.ls[2] : 1'b0; // R13
    // Bus data phase: writes land here
    s_d.wr = bus_take && ahb_in.hwrite;
    s_d.rd = bus_take && !ahb_in.hwrite;
    s_d.addr = ahb_in.haddr[7:0];
    if (s_q.wr) begin
      unique case (s_q.addr)
        `RP_OFF_CTRL: s_d.ctrl = {1'b0, ahb_in.hwdata[6:0]};
        `RP_OFF_SETPOINT: s_d.setpoint = ahb_in.hwdata[15:0];
        `RP_OFF_THRESH: s_d.thresh = ahb_in.hwdata[15:0];
        `RP_OFF_GAIN: s_d.gain = ahb_in.hwdata[15:0];
        `RP_OFF_TI: s_d.ti = ahb_in.hwdata[15:0];
        `RP_OFF_TD: s_d.td = ahb_in.hwdata[15:0];
        `RP_OFF_LIMITS: begin
          // Maximum above its ceiling is stored as the ceiling, so reads show the limit in force
          s_d.limits[15:8] = (ahb_in.hwdata[15:8] > `RP_OUTMAX_RST) ? `RP_OUTMAX_RST :
                             ahb_in.hwdata[15:8]; // R18
          s_d.limits[7:0] = ahb_in.hwdata[7:0];
        end
        `RP_OFF_FF: s_d.ff = ahb_in.hwdata;
        `RP_OFF_BATT_MAX: s_d.batt_max = ahb_in.hwdata[7:0];
        `RP_OFF_AUX_CFG: s_d.aux_cfg = ahb_in.hwdata[15:0];
        default: ;
      endcase
      // Override enable kept in ctrl bit 7 slot of aux: bit 8 of the word
      if (s_q.addr == `RP_OFF_CTRL) begin
        s_d.ctrl[`RP_CTRL_AUX_OVR - 1] = ahb_in.hwdata[`RP_CTRL_AUX_OVR];
      end
    end
    // Fault: set wins over a clear arriving in the same cycle
    if (s_q.wr && s_q.addr == `RP_OFF_CTRL && ahb_in.hwdata[`RP_CTRL_CLEAR]) begin
      s_d.fault = 1'b0; // R9
    end
    if (over_pressure) begin
      s_d.fault = 1'b1; // R8
    end
    if (s_q.fault || over_pressure) begin
      s_d.ls = 4'h0; // R8
    end
    // Read data for next data phase
    unique case (ahb_in.haddr[7:0])
      `RP_OFF_CTRL: s_d.rdata = {23'h0, s_q.ctrl[7], 1'b0, s_q.ctrl[6:0]};
      `RP_OFF_SETPOINT: s_d.rdata = {16'h0, s_q.setpoint};
      `RP_OFF_THRESH: s_d.rdata = {16'h0, s_q.thresh};
      `RP_OFF_GAIN: s_d.rdata = {16'h0, s_q.gain};
      `RP_OFF_TI: s_d.rdata = {16'h0, s_q.ti};
      `RP_OFF_TD: s_d.rdata = {16'h0, s_q.td};
      `RP_OFF_LIMITS: s_d.rdata = {16'h0, s_q.limits};
      `RP_OFF_FF: s_d.rdata = s_q.ff;
      `RP_OFF_BATT_MAX: s_d.rdata = {24'h0, s_q.batt_max};
      `RP_OFF_AUX_CFG: s_d.rdata = {16'h0, s_q.aux_cfg};
      `RP_OFF_STATUS: s_d.rdata = {28'h0, pressure_present_w(), s_q.fault, 2'b00}; // R11
      `RP_OFF_TERMS: s_d.rdata = {s_q.p_term, s_q.i_term}; // R19
      `RP_OFF_DUTY: s_d.rdata = {s_q.d_term, s_q.high_duty, s_q.inlet_duty}; // R19
      `RP_OFF_AUX_OUT: s_d.rdata = {8'h00, pressure, s_q.aux_out};
      default: s_d.rdata = 32'h0;
    endcase
  end

  function automatic logic pressure_present_w();
    return module_inserted_in && module_powered_in; // R11
  endfunction : pressure_present_w

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.thresh <= `RP_THRESH_RST;
      s_q.limits <= {`RP_OUTMAX_RST, 8'h00};
      s_q.ff <= 32'hFF00_0000;
      s_q.batt_max <= 8'hFF;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; every access answers with zero wait states
  assign ahb_out.hrdata = s_q.rdata;
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp = 1'b0;
  assign lowside_out = s_q.ls;
  assign driver_module_present_out = pressure_present_w(); // R11
  assign pressure_fault_flag_out = s_q.fault;

  // Every target selector entry gets the aux output; no enable bit gates it
  genvar g;
  for (g = 0; g < TARGETS; g++) begin : g_tgt
    assign aux_target_values_out[g*8 +: 8] = s_q.aux_out; // R3
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence over_seen;
    over_pressure;
  endsequence
  chk_fault_latch: assert property (@(posedge clk_in) disable iff (!resetn_in)
    over_seen |=> s_q.fault) else $error("fault not latched"); // R8
  chk_fault_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_q.fault |=> s_q.ls == 4'h0) else $error("channels on during fault"); // R8
  chk_fault_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_q.fault && !(s_q.wr && s_q.addr == `RP_OFF_CTRL) |=> s_q.fault)
    else $error("fault dropped"); // R9
  chk_inlet_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !s_q.ctrl[`RP_CTRL_INLET_EN] |=> !s_q.ls[0]) else $error("inlet driven"); // R14
  chk_pair_lock: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_q.ctrl[`RP_CTRL_LOCK] |=> s_q.ls[1] == s_q.ls[0]) else $error("pair split"); // R13
  chk_duty_max: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_q.ff[23:16] <= duty_max_eff && s_q.tick == 32'h0 |=> s_q.inlet_duty <= $past(duty_max_eff))
    else $error("duty over max"); // R21
  chk_zero_gain: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_q.tick == 32'h0 && s_q.gain == 16'sh0000 |=> s_q.p_term == 16'sh0000)
    else $error("gain zero term"); // R15
  chk_present: assert property (@(posedge clk_in) disable iff (!resetn_in)
    driver_module_present_out == (module_inserted_in && module_powered_in))
    else $error("presence wrong"); // R11

  // ------------------------------------------------------------
  // Loop update, auxiliary tail, second pair lock and fault clear assertions
  // ------------------------------------------------------------
  // The loop only moves on the update edge; the term and constant duty checks start there
  sequence update_edge;
    s_q.tick == 32'h0;
  endsequence
  // Zero gain must silence the integral and derivative terms too
  chk_gain_zero_id: assert property (@(posedge clk_in) disable iff (!resetn_in) // R15
    update_edge ##0 s_q.gain == 16'sh0000 |=> s_q.i_term == 16'sh0000 && s_q.d_term == 16'sh0000)
    else $error("zero gain left a term");
  // With nonzero gain, zero integral time empties the accumulator instead of dividing by zero
  chk_ti_zero: assert property (@(posedge clk_in) disable iff (!resetn_in) // R16
    update_edge ##0 (s_q.gain != 16'sh0000 && s_q.ti == 16'h0000) |=> s_q.integ == 32'sh0)
    else $error("integral kept with zero time");
  // Zero derivative time removes the derivative term
  chk_td_zero: assert property (@(posedge clk_in) disable iff (!resetn_in) // R17
    update_edge ##0 (s_q.gain != 16'sh0000 && s_q.td == 16'h0000) |=> s_q.d_term == 16'sh0000)
    else $error("derivative kept with zero time");
  // The update counter never passes its period
  chk_tick_range: assert property (@(posedge clk_in) disable iff (!resetn_in) // R20
    s_q.tick < 32'(UPDATE_CYC)) else $error("update counter out of range");
  // Between update edges the duties do not move, whatever software writes
  chk_duty_hold: assert property (@(posedge clk_in) disable iff (!resetn_in) // R20
    s_q.tick != 32'h0 |=> $stable(s_q.inlet_duty) && $stable(s_q.high_duty))
    else $error("duty moved off the update edge");
  // In inlet mode the high pressure valve follows its constant duty
  chk_high_const: assert property (@(posedge clk_in) disable iff (!resetn_in) // R5
    update_edge ##0 (s_q.ctrl[`RP_CTRL_MODE] == MODE_INLET && s_q.ff[23:16] <= s_q.ff[15:8] &&
    s_q.ff[15:8] <= duty_max_eff) |=> s_q.high_duty == $past(s_q.ff[15:8]))
    else $error("high valve not at constant duty");
  // In high pressure mode the inlet valve follows its constant duty
  chk_inlet_const: assert property (@(posedge clk_in) disable iff (!resetn_in) // R6
    update_edge ##0 (s_q.ctrl[`RP_CTRL_MODE] == MODE_HIGH && s_q.ff[23:16] <= s_q.ff[15:8] &&
    s_q.ff[15:8] <= duty_max_eff) |=> s_q.inlet_duty == $past(s_q.ff[15:8]))
    else $error("inlet valve not at constant duty");
  // Override replaces the combined auxiliary output one clock later
  chk_aux_override: assert property (@(posedge clk_in) disable iff (!resetn_in) // R2
    s_q.ctrl[`RP_CTRL_AUX_OVR - 1] |=> s_q.aux_out == $past(s_q.aux_cfg[15:8]))
    else $error("override value not applied");
  // Without override, small inputs add without saturation
  chk_aux_sum: assert property (@(posedge clk_in) disable iff (!resetn_in) // R1
    !s_q.ctrl[`RP_CTRL_AUX_OVR - 1] && aux_loop_pid_in < 16'h0080 && s_q.aux_cfg[7:0] < 8'h80
    |=> s_q.aux_out == $past(aux_loop_pid_in[7:0] + s_q.aux_cfg[7:0]))
    else $error("aux sum wrong");
  // The stored output maximum never exceeds its ceiling
  chk_limit_clip: assert property (@(posedge clk_in) disable iff (!resetn_in) // R18
    s_q.limits[15:8] <= `RP_OUTMAX_RST) else $error("output max above ceiling");
  // Limited loop output stays under the effective maximum when limits are sane
  chk_pid_lim: assert property (@(posedge clk_in) disable iff (!resetn_in) // R18
    s_q.limits[7:0] <= out_max_eff |-> pid_lim <= out_max_eff && pid_lim >= s_q.limits[7:0])
    else $error("loop output outside limits");
  // Second pair follows the first pair's lock rule
  chk_pair_lock_hi: assert property (@(posedge clk_in) disable iff (!resetn_in) // R13
    s_q.ctrl[`RP_CTRL_LOCK] |=> s_q.ls[3] == s_q.ls[2]) else $error("second pair split");
  // A clear with the pressure back below threshold drops the fault
  chk_fault_clear: assert property (@(posedge clk_in) disable iff (!resetn_in) // R9
    s_q.wr && s_q.addr == `RP_OFF_CTRL && ahb_in.hwdata[`RP_CTRL_CLEAR] && !over_pressure
    |=> !s_q.fault) else $error("fault not cleared");
endmodule : rail_pressure_pid_control

//--- test/rail_pressure_pid_control_tb.sv
// Self-checking bench: AHB-Lite master tasks, sensor model, PWM duty counting.
// Assumes zero-wait-state slave and inlet valve on locked channels 0 and 1.
`timescale 1ns/100ps
`include "rail_pid_map.svh"
module rail_pressure_pid_control_tb;
  import rail_pid_pkg::*;
  localparam int UPD = 16;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  ahb_req_s ahb_req;
  ahb_rsp_s ahb_rsp;
  logic [63:0] analog;
  logic inserted = 1'b0;
  logic powered = 1'b0;
  logic [15:0] aux_pid = 16'h0000;
  logic [3:0] lowside;
  logic present;
  logic fault;
  logic [31:0] aux_vals;
  logic [1:0] rail_chan = 2'h0;
  logic [15:0] rail_bar = 16'h0000;
  int fails = 0;
  int check_count = 0;
  int seed = 99166;
  assign ahb_req = '{haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2, hsel: hsel,
                     hready: ahb_rsp.hreadyout, hwdata: hwdata};
  rail_pressure_pid_control #(.UPDATE_CYC(UPD), .TARGETS(4)) DUT (.clk_in(clk_in),
    .resetn_in(resetn_in), .ahb_in(ahb_req), .ahb_out(ahb_rsp), .analog_in(analog),
    .module_inserted_in(inserted), .module_powered_in(powered), .aux_loop_pid_in(aux_pid),
    .lowside_out(lowside), .driver_module_present_out(present),
    .pressure_fault_flag_out(fault), .aux_target_values_out(aux_vals));
  rail_sensor_model far_side (.clk_in(clk_in), .lowside_in(lowside),
    .rail_chan_in(rail_chan), .rail_bar_in(rail_bar), .analog_out(analog));
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  // -----------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge clk_in); while (ahb_rsp.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (ahb_rsp.hreadyout !== 1'b1);
    rd = ahb_rsp.hrdata;
  endtask : bus
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // High cycles of the inlet pair over one PWM period; pair must move together
  task automatic duty_of(output int n);
    n = 0;
    repeat (100) begin
      @(negedge clk_in);
      n += lowside[0];
      check("pair", {31'h0, lowside[1]}, {31'h0, lowside[0]});
    end
  endtask : duty_of
  function automatic int exp_inlet(logic md, logic en, int cd, int ff, int lmin, int mn,
                                   int mx, int bm);
    int d;
    int cap;
    d = md ? cd : lmin + ff;
    cap = (mx < bm) ? mx : bm;
    if (d < mn) d = mn;
    if (d > cap) d = cap;
    return en ? d : 0;
  endfunction : exp_inlet
  initial begin
    #3000000;
    fails++;
    conclude();
  end
  initial begin
    int n;
    logic md;
    logic en;
    int cd;
    int ff;
    int lmin;
    int mn;
    int mx;
    int bm;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    bus(0, `RP_OFF_THRESH, 0);
    check("thresh rst", rd, {16'h0000, `RP_THRESH_RST});
    bus(1, 8'h3C, 32'hFFFFFFFF);
    bus(0, 8'h3C, 0);
    check("unmapped", rd, 32'h00000000);
    bus(1, `RP_OFF_GAIN, 0);
    bus(1, `RP_OFF_TI, 0);
    bus(1, `RP_OFF_TD, 0);
    bus(1, `RP_OFF_LIMITS, 32'h00003200);
    bus(0, `RP_OFF_LIMITS, 0);
    check("out max clip", {24'h0, rd[15:8]}, {24'h0, `RP_OUTMAX_RST});
    // Presence from every insert and power combination
    for (int i = 0; i < 4; i++) begin
      inserted <= i[0];
      powered <= i[1];
      bus(0, `RP_OFF_STATUS, 0);
      check("present", {31'h0, present}, {31'h0, i[0] & i[1]});
      check("status present", {31'h0, rd[3]}, {31'h0, i[0] & i[1]});
    end
    // Duty for random settings; gain zero leaves only limits and feed forward
    for (int i = 0; i < 8; i++) begin
      md = $random(seed);
      en = (i == 0) ? 1'b1 : $random(seed);
      cd = (i == 0) ? 50 : $urandom(seed) % 61;
      ff = $urandom(seed) % 21;
      lmin = $urandom(seed) % 11;
      mn = $urandom(seed) % 11;
      mx = 30 + $urandom(seed) % 71;
      bm = (i == 0) ? 20 : 30 + $urandom(seed) % 71;
      bus(1, `RP_OFF_LIMITS, {16'h0, 8'h1E, lmin[7:0]});
      bus(1, `RP_OFF_FF, {mx[7:0], mn[7:0], cd[7:0], ff[7:0]});
      bus(1, `RP_OFF_BATT_MAX, bm);
      bus(1, `RP_OFF_CTRL, {25'h0, 4'h8, 1'b1, en, md});
      repeat (2 * UPD + 110) @(posedge clk_in);
      duty_of(n);
      check("inlet duty", n, exp_inlet(md, en, cd, ff, lmin, mn, mx, bm));
      bus(0, `RP_OFF_TERMS, 0);
      check("terms", rd, 32'h00000000);
    end
    // Over-pressure on channel 2 only counts once channel 2 is selected
    bus(1, `RP_OFF_THRESH, 32'h00000200);
    rail_chan <= 2'h2;
    rail_bar <= 16'h0300;
    bus(1, `RP_OFF_CTRL, 32'h00000056);
    repeat (2 * UPD + 4) @(posedge clk_in);
    check("fault other chan", {31'h0, fault}, 32'h0);
    bus(1, `RP_OFF_CTRL, 32'h00000066);
    repeat (2 * UPD + 4) @(posedge clk_in);
    check("fault", {31'h0, fault}, 32'h1);
    duty_of(n);
    check("channels off", {28'h0, lowside}, 32'h0);
    bus(1, `RP_OFF_CTRL, 32'h000000E6);
    repeat (4) @(posedge clk_in);
    check("clear while high", {31'h0, fault}, 32'h1);
    rail_bar <= 16'h0100;
    repeat (2 * UPD + 4) @(posedge clk_in);
    bus(0, `RP_OFF_STATUS, 0);
    check("fault held", {31'h0, rd[2]}, 32'h1);
    bus(1, `RP_OFF_CTRL, 32'h000000E6);
    repeat (4) @(posedge clk_in);
    check("fault cleared", {31'h0, fault}, 32'h0);
    // Auxiliary sum, then override, copied to every target
    for (int i = 0; i < 4; i++) begin
      aux_pid <= $urandom(seed) % 61;
      ff = $urandom(seed) % 61;
      cd = $urandom(seed) % 101;
      bus(1, `RP_OFF_AUX_CFG, {16'h0, cd[7:0], ff[7:0]});
      bus(1, `RP_OFF_CTRL, 32'h00000066);
      repeat (2 * UPD + 4) @(posedge clk_in);
      for (int t = 0; t < 4; t++) check("aux sum", aux_vals[t*8 +: 8], aux_pid + ff);
      bus(1, `RP_OFF_CTRL, 32'h00000166);
      repeat (2 * UPD + 4) @(posedge clk_in);
      for (int t = 0; t < 4; t++) check("aux override", aux_vals[t*8 +: 8], cd);
    end
    conclude();
  end
endmodule : rail_pressure_pid_control_tb

//--- test/rail_sensor_model.sv
// Behavioural rail pressure sensor and valve load on the four analog inputs.
// Assumes the bench sets the rail level and the channel that carries it.
`timescale 1ns/100ps
module rail_sensor_model (
  input wire logic clk_in,
  input wire logic [3:0] lowside_in,
  input wire logic [1:0] rail_chan_in,
  input wire logic [15:0] rail_bar_in,
  output logic [63:0] analog_out
);
  logic [7:0] noise_q = 8'h00;
  // Idle channels wander, but stay below any threshold the bench uses
  always_ff @(posedge clk_in) begin
    noise_q <= noise_q + 8'h01;
  end
  // An open inlet valve bleeds one bar off the rail
  always_comb begin
    analog_out = {4{8'h00, noise_q}};
    // An empty rail cannot bleed below zero
    analog_out[rail_chan_in*16 +: 16] = rail_bar_in -
      ((rail_bar_in != 16'h0000) ? {15'h0000, lowside_in[0]} : 16'h0000);
  end
endmodule : rail_sensor_model
